/* File: pkg/mau_map.svh */
// Constants of the multiply-accumulate unit: bit positions, reset values, timing.
`ifndef MAU_MAP_SVH
`define MAU_MAP_SVH

// ****************************************************************************
// Status register layout
// ****************************************************************************
`define MAU_STAT_SU_BIT   6
`define MAU_STAT_FI_BIT   5
`define MAU_STAT_N_BIT    3
`define MAU_STAT_Z_BIT    2
`define MAU_STAT_V_BIT    1
`define MAU_STAT_EV_BIT   0
`define MAU_STAT_RST      32'h0000_0000
`define MAU_MASK_RST      32'h0000_0000

// ****************************************************************************
// Product shift factor codes
// ****************************************************************************
`define MAU_SF_NONE       2'h0
`define MAU_SF_LEFT       2'h1
`define MAU_SF_RIGHT      2'h3

// ****************************************************************************
// Pipeline timing
// ****************************************************************************
`define MAU_PIPE_DEPTH    4
`define MAU_STORE_STALL   (`MAU_PIPE_DEPTH - 1)

// ****************************************************************************
// Fractional extremes of a word and a longword
// ****************************************************************************
`define MAU_FRAC_W_MIN    16'h8000
`define MAU_FRAC_W_MAX    16'h7FFF
`define MAU_FRAC_L_MIN    32'h8000_0000
`define MAU_FRAC_L_MAX    32'h7FFF_FFFF

`endif

/* File: pkg/mau_pkg.sv */
// Types of the multiply-accumulate unit.
package mau_pkg;

  typedef enum logic [3:0] {
    MAU_OP_NOP,
    MAU_OP_MULS,
    MAU_OP_MULU,
    MAU_OP_MAC,
    MAU_OP_MAC_LOAD,
    MAU_OP_LD_ACC,
    MAU_OP_ST_ACC,
    MAU_OP_CP_ACC,
    MAU_OP_LD_STAT,
    MAU_OP_ST_STAT,
    MAU_OP_STAT_CCR,
    MAU_OP_LD_MASK,
    MAU_OP_ST_MASK,
    MAU_OP_LD_EXT,
    MAU_OP_ST_EXT
  } mau_op_e;

  typedef struct packed {
    logic        valid;    // Instruction in the address-generate/execute stage.
    mau_op_e     op;       // Operation.
    logic [1:0]  dst_acc;  // Destination accumulator.
    logic [1:0]  src_acc;  // Source accumulator for copy and store.
    logic        msub;     // Subtract the product instead of adding it.
    logic        word;     // 16-bit operands.
    logic        upper_x;  // Take the upper word of rx.
    logic        upper_y;  // Take the upper word of ry.
    logic [1:0]  sf;       // Product shift factor.
    logic        ext_high; // Extension word of pair two/three.
    logic [31:0] rx;       // First operand, or register/immediate value.
    logic [31:0] ry;       // Second operand.
    logic [31:0] mem_data; // Memory operand of the load variant.
    logic [3:0]  dst_reg;  // General register for results.
    logic [3:0]  load_reg; // General register loaded by the load variant.
  } mau_issue_s;

  typedef struct packed {
    logic        valid;
    logic [3:0]  reg_idx;
    logic [31:0] data;
  } mau_wb_s;

  typedef struct packed {
    logic        valid;
    mau_op_e     op;
    logic [1:0]  dst_acc;
    logic [1:0]  src_acc;
    logic        msub;
    logic        su;
    logic        fi;
    logic        ext_high;
    logic [1:0]  sf;
  } mau_pipe_s;

endpackage

/* File: core/mau_core.sv */
// Multiply-accumulate unit datapath with four 48-bit accumulators.
`timescale 1ns/1ns

`include "mau_map.svh"

module mau_core
  import mau_pkg::*;
(
  input  wire logic        ref_clk,    // Core clock, 125 MHz.
  input  wire logic        rst,        // Synchronous reset, active high.
  input  wire mau_issue_s  issue,      // Instruction in the execute stage.
  output mau_wb_s          wb_ff,      // Register result of a store or multiply.
  output mau_wb_s          ld_wb_ff,   // Register load of the load variant.
  output logic             ccr_vld_ff, // Condition code write strobe.
  output logic [3:0]       ccr_ff,     // Condition code value.
  output logic [3:0]       acc_busy_ff, // Accumulator has a write in flight.
  output logic             stat_busy_ff, // Status flags have a write in flight.
  output logic             refused_ff, // Store refused by the interlock.
  output logic [31:0]      mask_ff,    // Address mask for operand addressing.
  output logic [31:0]      stat_ff     // Status register.
);

  // **************************************************************************
  // Storage
  // **************************************************************************
  logic [31:0] acc_lo_ff [4];
  logic [15:0] acc_ext_ff [4];

  mau_pipe_s   st2_ff;
  mau_pipe_s   st3_ff;
  mau_pipe_s   st4_ff;
  logic signed [32:0] st2_x_ff;
  logic signed [32:0] st2_y_ff;
  logic [31:0] st2_val_ff;
  logic [31:0] st3_val_ff;
  logic [31:0] st4_val_ff;
  logic signed [65:0] st3_prod_ff;
  logic [47:0] st4_add_ff;

  // **************************************************************************
  // Issue decode
  // **************************************************************************
  function automatic logic [3:0] tgt_mask(input mau_op_e op, input logic [1:0] dst,
                                          input logic hi);
    logic [3:0] m;
    m = 4'h0;
    case (op)
      MAU_OP_MAC, MAU_OP_MAC_LOAD, MAU_OP_LD_ACC, MAU_OP_CP_ACC:
        m[dst] = 1'b1;
      MAU_OP_LD_EXT:
        m = hi ? 4'hC : 4'h3;
      default:
        m = 4'h0;
    endcase
    return m;
  endfunction

  logic        is_mac;
  logic        su_mode;
  logic        fi_mode;
  logic [31:0] sel_x;
  logic [31:0] sel_y;
  logic [3:0]  pair_mask;
  logic        store_blocked;
  logic [47:0] src_acc;

  assign su_mode   = stat_ff[`MAU_STAT_SU_BIT];
  assign fi_mode   = stat_ff[`MAU_STAT_FI_BIT];
  assign is_mac    = issue.valid && (issue.op == MAU_OP_MAC || issue.op == MAU_OP_MAC_LOAD);
  assign pair_mask = issue.ext_high ? 4'hC : 4'h3;
  assign src_acc   = {acc_ext_ff[issue.src_acc], acc_lo_ff[issue.src_acc]};

  // Only stores whose source is busy are refused; others pass freely.
  always_comb
  begin
    store_blocked = 1'b0;
    if (issue.valid)
    begin
      case (issue.op)
        MAU_OP_ST_ACC:                 store_blocked = acc_busy_ff[issue.src_acc];
        MAU_OP_ST_EXT:                 store_blocked = |(acc_busy_ff & pair_mask);
        MAU_OP_ST_STAT, MAU_OP_STAT_CCR: store_blocked = stat_busy_ff;
        default:                       store_blocked = 1'b0;
      endcase
    end
  end

  // Operand alignment per format; fractional words fill the low half with zeros.
  always_comb
  begin
    sel_x = issue.rx;
    sel_y = issue.ry;
    if (issue.word)
    begin
      sel_x = {16'h0000, issue.upper_x ? issue.rx[31:16] : issue.rx[15:0]};
      sel_y = {16'h0000, issue.upper_y ? issue.ry[31:16] : issue.ry[15:0]};
      if (fi_mode)
      begin
        sel_x = {sel_x[15:0], 16'h0000};
        sel_y = {sel_y[15:0], 16'h0000};
      end
      else if (!su_mode)
      begin
        sel_x = {{16{sel_x[15]}}, sel_x[15:0]};
        sel_y = {{16{sel_y[15]}}, sel_y[15:0]};
      end
    end
  end

  // **************************************************************************
  // Pipeline stage 1, in the core's execute cycle
  // **************************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st2_ff     <= '0;
      st2_x_ff   <= '0;
      st2_y_ff   <= '0;
      st2_val_ff <= '0;
    end
    else
    begin
      // Accumulator writers enter the pipe every cycle with no hold.
      st2_ff.valid    <= issue.valid && (tgt_mask(issue.op, issue.dst_acc,
                                                  issue.ext_high) != 4'h0);
      st2_ff.op       <= issue.op;
      st2_ff.dst_acc  <= issue.dst_acc;
      st2_ff.src_acc  <= issue.src_acc;
      st2_ff.msub     <= issue.msub;
      st2_ff.su       <= su_mode;
      st2_ff.fi       <= fi_mode;
      st2_ff.ext_high <= issue.ext_high;
      st2_ff.sf       <= issue.sf;
      // Unsigned operands get a zero top bit so one signed multiplier serves all.
      st2_x_ff   <= {(su_mode && !fi_mode) ? 1'b0 : sel_x[31], sel_x};
      st2_y_ff   <= {(su_mode && !fi_mode) ? 1'b0 : sel_y[31], sel_y};
      st2_val_ff <= issue.rx;
    end
  end

  // **************************************************************************
  // Pipeline stage 2, the multiply
  // **************************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st3_ff      <= '0;
      st3_prod_ff <= '0;
      st3_val_ff  <= '0;
    end
    else
    begin
      st3_ff      <= st2_ff;
      st3_prod_ff <= st2_x_ff * st2_y_ff;
      st3_val_ff  <= st2_val_ff;
    end
  end

  // **************************************************************************
  // Pipeline stage 3, product alignment and shift
  // **************************************************************************
  logic [63:0] frac_prod;
  logic [39:0] prod40;
  logic [47:0] prod48;
  logic        prod_signed;

  assign frac_prod   = {st3_prod_ff[62:0], 1'b0};
  assign prod40      = st3_ff.fi ? frac_prod[63:24] : st3_prod_ff[39:0];
  assign prod_signed = st3_ff.fi || !st3_ff.su;
  assign prod48      = {{8{prod_signed & prod40[39]}}, prod40};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st4_ff     <= '0;
      st4_add_ff <= '0;
      st4_val_ff <= '0;
    end
    else
    begin
      st4_ff     <= st3_ff;
      st4_val_ff <= st3_val_ff;
      // The shift factor is ignored in fractional mode.
      if (st3_ff.fi || st3_ff.sf == `MAU_SF_NONE)
        st4_add_ff <= prod48;
      else if (st3_ff.sf == `MAU_SF_LEFT)
        st4_add_ff <= {prod48[46:0], 1'b0};
      else if (st3_ff.sf == `MAU_SF_RIGHT)
        st4_add_ff <= {prod48[47], prod48[47:1]};
      else
        st4_add_ff <= prod48;
    end
  end

  // **************************************************************************
  // Pipeline stage 4, accumulator write
  // **************************************************************************
  logic [47:0] old_acc;
  logic [47:0] new_acc;
  logic [47:0] cp_acc;

  assign old_acc = {acc_ext_ff[st4_ff.dst_acc], acc_lo_ff[st4_ff.dst_acc]};
  assign cp_acc  = {acc_ext_ff[st4_ff.src_acc], acc_lo_ff[st4_ff.src_acc]};

  always_comb
  begin
    new_acc = old_acc;
    case (st4_ff.op)
      MAU_OP_MAC, MAU_OP_MAC_LOAD:
        new_acc = st4_ff.msub ? old_acc - st4_add_ff : old_acc + st4_add_ff;
      MAU_OP_LD_ACC:
        new_acc = {{16{!st4_ff.su & st4_val_ff[31]}}, st4_val_ff};
      MAU_OP_CP_ACC:
        new_acc = cp_acc;
      default:
        new_acc = old_acc;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        acc_lo_ff[i]  <= '0;
        acc_ext_ff[i] <= '0;
      end
    end
    else if (st4_ff.valid)
    begin
      if (st4_ff.op == MAU_OP_LD_EXT)
      begin
        // Even accumulator takes the low half, odd the high half.
        acc_ext_ff[{st4_ff.ext_high, 1'b0}] <= st4_val_ff[15:0];
        acc_ext_ff[{st4_ff.ext_high, 1'b1}] <= st4_val_ff[31:16];
      end
      else
      begin
        acc_lo_ff[st4_ff.dst_acc]  <= new_acc[31:0];
        acc_ext_ff[st4_ff.dst_acc] <= new_acc[47:32];
      end
    end
  end

  // **************************************************************************
  // Interlock tracking
  // **************************************************************************
  logic [3:0] mask2;
  logic [3:0] mask3;

  assign mask2 = st2_ff.valid ? tgt_mask(st2_ff.op, st2_ff.dst_acc, st2_ff.ext_high) : 4'h0;
  assign mask3 = st3_ff.valid ? tgt_mask(st3_ff.op, st3_ff.dst_acc, st3_ff.ext_high) : 4'h0;

  // Busy covers stages one to three, so a store right after a MAC waits three cycles.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      acc_busy_ff  <= '0;
      stat_busy_ff <= 1'b0;
      refused_ff   <= 1'b0;
    end
    else
    begin
      acc_busy_ff  <= (issue.valid ? tgt_mask(issue.op, issue.dst_acc, issue.ext_high) : 4'h0)
                      | mask2 | mask3;
      stat_busy_ff <= is_mac
                      || (st2_ff.valid && (st2_ff.op == MAU_OP_MAC || st2_ff.op == MAU_OP_MAC_LOAD))
                      || (st3_ff.valid && (st3_ff.op == MAU_OP_MAC || st3_ff.op == MAU_OP_MAC_LOAD));
      refused_ff   <= store_blocked;
    end
  end

  // **************************************************************************
  // Status and mask registers
  // **************************************************************************
  logic mac_done;

  assign mac_done = st4_ff.valid && (st4_ff.op == MAU_OP_MAC || st4_ff.op == MAU_OP_MAC_LOAD);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      stat_ff <= `MAU_STAT_RST;
    else if (issue.valid && issue.op == MAU_OP_LD_STAT)
      stat_ff <= issue.rx;
    else if (mac_done)
    begin
      stat_ff[`MAU_STAT_N_BIT]  <= new_acc[47];
      stat_ff[`MAU_STAT_Z_BIT]  <= (new_acc == 48'h0000_0000_0000);
      stat_ff[`MAU_STAT_EV_BIT] <= !(&new_acc[47:31] || !(|new_acc[47:31]));
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      mask_ff <= `MAU_MASK_RST;
    else if (issue.valid && issue.op == MAU_OP_LD_MASK)
      mask_ff <= issue.rx;
  end

  // **************************************************************************
  // Register results
  // **************************************************************************
  logic signed [65:0] mul_s;
  logic        [63:0] mul_u;

  assign mul_s = $signed({issue.rx[31], issue.rx}) * $signed({issue.ry[31], issue.ry});
  assign mul_u = issue.rx * issue.ry;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wb_ff      <= '0;
      ccr_vld_ff <= 1'b0;
      ccr_ff     <= '0;
    end
    else
    begin
      wb_ff.valid   <= 1'b0;
      wb_ff.reg_idx <= issue.dst_reg;
      ccr_vld_ff    <= 1'b0;
      if (issue.valid && !store_blocked)
      begin
        case (issue.op)
          MAU_OP_MULS:
          begin
            wb_ff.valid <= 1'b1;
            wb_ff.data  <= mul_s[31:0];
          end
          MAU_OP_MULU:
          begin
            wb_ff.valid <= 1'b1;
            wb_ff.data  <= mul_u[31:0];
          end
          MAU_OP_ST_ACC:
          begin
            wb_ff.valid <= 1'b1;
            wb_ff.data  <= src_acc[31:0];
          end
          MAU_OP_ST_STAT:
          begin
            wb_ff.valid <= 1'b1;
            wb_ff.data  <= stat_ff;
          end
          MAU_OP_STAT_CCR:
          begin
            ccr_vld_ff <= 1'b1;
            ccr_ff     <= stat_ff[3:0];
          end
          MAU_OP_ST_MASK:
          begin
            wb_ff.valid <= 1'b1;
            wb_ff.data  <= mask_ff;
          end
          MAU_OP_ST_EXT:
          begin
            wb_ff.valid <= 1'b1;
            wb_ff.data  <= {acc_ext_ff[{issue.ext_high, 1'b1}],
                            acc_ext_ff[{issue.ext_high, 1'b0}]};
          end
          default:
            wb_ff.valid <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ld_wb_ff <= '0;
    else
    begin
      ld_wb_ff.valid   <= issue.valid && issue.op == MAU_OP_MAC_LOAD;
      ld_wb_ff.reg_idx <= issue.load_reg;
      ld_wb_ff.data    <= issue.mem_data;
    end
  end

endmodule // mau_core

/* File: sim/mau_core_assertions.sv */
// Port-level checks of the multiply-accumulate unit.
`timescale 1ns/1ns

module mau_core_checker
  import mau_pkg::*;
(
  input wire logic        ref_clk,      // Core clock.
  input wire logic        rst,          // Synchronous reset.
  input wire mau_issue_s  issue,        // Issued instruction.
  input wire mau_wb_s     wb_ff,        // Register result.
  input wire mau_wb_s     ld_wb_ff,     // Load variant result.
  input wire logic        ccr_vld_ff,   // Condition code strobe.
  input wire logic [3:0]  ccr_ff,       // Condition code value.
  input wire logic [3:0]  acc_busy_ff,  // Accumulator busy.
  input wire logic        stat_busy_ff, // Flags pending.
  input wire logic        refused_ff,   // Store refused.
  input wire logic [31:0] mask_ff,      // Address mask.
  input wire logic [31:0] stat_ff       // Status register.
);
  // ****************************************************************
  // Helper logic and sequences
  // ****************************************************************
  logic [31:0] prod_ff;

  always_ff @(posedge ref_clk)
  begin
    prod_ff <= issue.rx * issue.ry;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_mac_issue;
    issue.valid && (issue.op == MAU_OP_MAC || issue.op == MAU_OP_MAC_LOAD);
  endsequence
  sequence s_busy_run;
    stat_busy_ff [*3];
  endsequence
  sequence s_store_acc;
    issue.valid && issue.op == MAU_OP_ST_ACC;
  endsequence

  chk_mul_result: assert property (issue.valid && issue.op inside {MAU_OP_MULS, MAU_OP_MULU}
    |=> wb_ff.valid && wb_ff.data == prod_ff) else $error("multiply result wrong");
  chk_mask_load: assert property (issue.valid && issue.op == MAU_OP_LD_MASK
    |=> mask_ff == $past(issue.rx)) else $error("mask load wrong");
  chk_stat_load: assert property (issue.valid && issue.op == MAU_OP_LD_STAT
    |=> stat_ff == $past(issue.rx)) else $error("status load wrong");
  chk_ccr_copy: assert property (issue.valid && issue.op == MAU_OP_STAT_CCR && !stat_busy_ff
    |=> ccr_vld_ff && ccr_ff == $past(stat_ff[3:0])) else $error("ccr copy wrong");
  chk_flags_pending: assert property (s_mac_issue |=> s_busy_run)
    else $error("flags not pending for three cycles");
  chk_store_refused: assert property (s_store_acc ##0 acc_busy_ff[issue.src_acc]
    |=> refused_ff && !wb_ff.valid) else $error("busy store not refused");
  chk_store_quiet: assert property (s_store_acc ##0 !acc_busy_ff[issue.src_acc]
    |=> wb_ff.valid && !refused_ff) else $error("free store not answered");
  chk_writer_free: assert property (issue.valid
    && issue.op inside {MAU_OP_MAC, MAU_OP_LD_ACC, MAU_OP_CP_ACC}
    |=> !refused_ff && acc_busy_ff[$past(issue.dst_acc)])
    else $error("accumulator writer stalled");
  chk_load_variant: assert property (issue.valid && issue.op == MAU_OP_MAC_LOAD
    |=> ld_wb_ff.valid && ld_wb_ff.data == $past(issue.mem_data)
    && ld_wb_ff.reg_idx == $past(issue.load_reg)) else $error("load variant wrong");
endmodule // mau_core_checker

bind mau_core mau_core_checker mau_core_checker_inst (.ref_clk(ref_clk), .rst(rst),
  .issue(issue), .wb_ff(wb_ff), .ld_wb_ff(ld_wb_ff), .ccr_vld_ff(ccr_vld_ff),
  .ccr_ff(ccr_ff), .acc_busy_ff(acc_busy_ff), .stat_busy_ff(stat_busy_ff),
  .refused_ff(refused_ff), .mask_ff(mask_ff), .stat_ff(stat_ff));

/* File: sim/mau_core_model.sv */
// Core-side issue model that holds stores while the unit is busy.
`timescale 1ns/1ns

module mau_core_model
  import mau_pkg::*;
(
  input  wire mau_issue_s  cmd,          // Instruction the program wants to issue.
  input  wire logic        raw,          // Skip the interlock to provoke a refusal.
  input  wire logic [3:0]  acc_busy_ff,  // Accumulator busy.
  input  wire logic        stat_busy_ff, // Flags pending.
  output mau_issue_s       issue,        // Instruction presented to the unit.
  output logic             held          // Store held in the execute stage.
);
  logic busy;

  always_comb
  begin
    case (cmd.op)
      MAU_OP_ST_ACC:   busy = acc_busy_ff[cmd.src_acc];
      MAU_OP_ST_EXT:   busy = cmd.ext_high ? |acc_busy_ff[3:2] : |acc_busy_ff[1:0];
      MAU_OP_ST_STAT,
      MAU_OP_STAT_CCR: busy = stat_busy_ff;
      default:         busy = 1'b0;
    endcase
    held = cmd.valid && busy && !raw;
    // A held slot shows inverted fields so stale operands cannot pass for live ones.
    issue = held ? ~cmd : cmd;
    issue.valid = cmd.valid && !held;
  end
endmodule // mau_core_model

/* File: sim/mau_core_test.sv */
// Self-checking bench of the multiply-accumulate unit.
`timescale 1ns/1ns
`include "mau_map.svh"

`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      errors++; \
      $display("unexpected %s: expected %h, seen %h", nm, ex, got); \
    end \
  end

module mau_core_test
  import mau_pkg::*;
;
  typedef struct {mau_op_e op; logic [31:0] rx; logic [31:0] ry; int kind;
                  logic [31:0] exp;} mau_row_s;

  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        raw = 1'b0;
  mau_issue_s  cmd = '0;
  mau_issue_s  issue;
  mau_wb_s     wb_ff;
  mau_wb_s     ld_wb_ff;
  logic        ccr_vld_ff;
  logic [3:0]  ccr_ff;
  logic [3:0]  acc_busy_ff;
  logic        stat_busy_ff;
  logic        refused_ff;
  logic [31:0] mask_ff;
  logic [31:0] stat_ff;
  logic        held;
  int          errors = 0;
  int          samples_checked = 0;
  int          stalls = 0;
  int          cycles = 0;
  mau_row_s    rows[8] = '{
    '{MAU_OP_MULS, 32'hFFFF_FFFD, 32'h0000_0007, 0, 32'hFFFF_FFEB},
    '{MAU_OP_MULU, 32'h0001_0001, 32'h0001_0003, 0, 32'h0004_0003},
    '{MAU_OP_LD_MASK, 32'h1234_5678, '0, 1, 32'h1234_5678},
    '{MAU_OP_ST_MASK, '0, '0, 0, 32'h1234_5678},
    '{MAU_OP_LD_STAT, 32'h0000_000D, '0, 2, 32'h0000_000D},
    '{MAU_OP_ST_STAT, '0, '0, 0, 32'h0000_000D},
    '{MAU_OP_STAT_CCR, '0, '0, 3, 32'h0000_000D},
    '{MAU_OP_LD_STAT, '0, '0, 2, '0}};

  always #4 ref_clk = ~ref_clk;

  mau_core mau_core_inst (.ref_clk(ref_clk), .rst(rst), .issue(issue), .wb_ff(wb_ff),
    .ld_wb_ff(ld_wb_ff), .ccr_vld_ff(ccr_vld_ff), .ccr_ff(ccr_ff),
    .acc_busy_ff(acc_busy_ff), .stat_busy_ff(stat_busy_ff), .refused_ff(refused_ff),
    .mask_ff(mask_ff), .stat_ff(stat_ff));
  mau_core_model mau_core_model_inst (.cmd(cmd), .raw(raw), .acc_busy_ff(acc_busy_ff),
    .stat_busy_ff(stat_busy_ff), .issue(issue), .held(held));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Called at a clock edge; returns at the edge where the unit took the instruction.
  task automatic send(input mau_issue_s t);
    cmd <= t;
    @(posedge ref_clk);
    while (held === 1'b1)
    begin
      stalls++;
      @(posedge ref_clk);
    end
  endtask

  task automatic idle();
    mau_issue_s n;
    n = ~cmd;
    n.valid = 1'b0;
    send(n);
  endtask

  task automatic op(input mau_op_e o, input logic [1:0] d, input logic [1:0] s,
                    input logic [31:0] x, input logic [31:0] y, input logic m = 1'b0);
    mau_issue_s t;
    t = '0;
    t.valid = 1'b1;
    t.op = o;
    t.dst_acc = d;
    t.src_acc = s;
    t.ext_high = d[1] | s[1];
    t.msub = m;
    t.rx = x;
    t.ry = y;
    t.mem_data = 32'hC0DE_0042;
    t.dst_reg = 4'h5;
    t.load_reg = 4'h9;
    send(t);
  endtask

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      finish_test();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (rows[i])
    begin
      op(rows[i].op, 2'h0, 2'h0, rows[i].rx, rows[i].ry);
      idle();
      case (rows[i].kind)
        0: `CHK("wb data", rows[i].exp, wb_ff.data)
        1: `CHK("mask", rows[i].exp, mask_ff)
        2: `CHK("status", rows[i].exp, stat_ff)
        default: `CHK("ccr", rows[i].exp[3:0], ccr_ff)
      endcase
    end
    // Back-to-back writers, then a store right behind a subtracting MAC.
    op(MAU_OP_LD_ACC, 2'h0, 2'h0, 32'h0000_0005, '0);
    op(MAU_OP_MAC, 2'h0, 2'h0, 32'h0000_0003, 32'h0000_0004);
    op(MAU_OP_MAC, 2'h0, 2'h0, 32'h0000_0002, 32'h0000_0001, 1'b1);
    stalls = 0;
    op(MAU_OP_ST_ACC, 2'h0, 2'h0, '0, '0);
    idle();
    `CHK("stalls", `MAU_STORE_STALL, stalls)
    `CHK("acc0", 32'h0000_000F, wb_ff.data)
    `CHK("wb reg", 4'h5, wb_ff.reg_idx)
    // A store of an idle accumulator behind a MAC elsewhere goes straight through.
    op(MAU_OP_MAC, 2'h1, 2'h0, 32'h0000_0003, 32'h0000_0003);
    stalls = 0;
    op(MAU_OP_ST_ACC, 2'h0, 2'h0, '0, '0);
    idle();
    `CHK("free stalls", 0, stalls)
    `CHK("acc0 again", 32'h0000_000F, wb_ff.data)
    op(MAU_OP_LD_EXT, 2'h0, 2'h0, 32'hABCD_1234, '0);
    op(MAU_OP_CP_ACC, 2'h2, 2'h0, '0, '0);
    op(MAU_OP_ST_ACC, 2'h0, 2'h2, '0, '0);
    idle();
    `CHK("acc2", 32'h0000_000F, wb_ff.data)
    op(MAU_OP_ST_EXT, 2'h0, 2'h2, '0, '0);
    idle();
    `CHK("ext high", 32'h0000_1234, wb_ff.data)
    op(MAU_OP_ST_EXT, 2'h0, 2'h0, '0, '0);
    idle();
    `CHK("ext low", 32'hABCD_1234, wb_ff.data)
    op(MAU_OP_MAC_LOAD, 2'h3, 2'h0, 32'h0000_0002, 32'h0000_0003);
    idle();
    `CHK("load data", 32'hC0DE_0042, ld_wb_ff.data)
    `CHK("load reg", 4'h9, ld_wb_ff.reg_idx)
    op(MAU_OP_ST_ACC, 2'h0, 2'h3, '0, '0);
    idle();
    `CHK("acc3", 32'h0000_0006, wb_ff.data)
    // A store pushed past the interlock must be refused.
    op(MAU_OP_MAC, 2'h0, 2'h0, 32'h0000_0001, 32'h0000_0001);
    raw <= 1'b1;
    op(MAU_OP_ST_ACC, 2'h0, 2'h0, '0, '0);
    raw <= 1'b0;
    idle();
    `CHK("refused", 1'b1, refused_ff)
    `CHK("no wb", 1'b0, wb_ff.valid)
    // Fractional: minus one times one half.
    op(MAU_OP_LD_STAT, 2'h0, 2'h0, 32'h0000_0020, '0);
    op(MAU_OP_LD_ACC, 2'h1, 2'h0, '0, '0);
    op(MAU_OP_MAC, 2'h1, 2'h0, `MAU_FRAC_L_MIN, 32'h4000_0000);
    op(MAU_OP_ST_ACC, 2'h0, 2'h1, '0, '0);
    idle();
    `CHK("frac low", 32'h0000_0000, wb_ff.data)
    `CHK("frac sign", 1'b1, stat_ff[`MAU_STAT_N_BIT])
    op(MAU_OP_ST_EXT, 2'h0, 2'h0, '0, '0);
    idle();
    `CHK("frac ext", 32'hFFC0_1234, wb_ff.data)
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK("mask reset", 32'h0000_0000, mask_ff)
    `CHK("status reset", 32'h0000_0000, stat_ff)
    // Unsigned integer: the product is zero-filled, so the extension shows no sign.
    op(MAU_OP_LD_STAT, 2'h0, 2'h0, 32'h0000_0040, '0);
    op(MAU_OP_LD_ACC, 2'h2, 2'h0, '0, '0);
    op(MAU_OP_MAC, 2'h2, 2'h0, 32'hFFFF_FFFF, 32'h0000_0002);
    op(MAU_OP_ST_EXT, 2'h0, 2'h2, '0, '0);
    idle();
    `CHK("unsigned ext", 32'h0000_0001, wb_ff.data)
    finish_test();
  end
endmodule // mau_core_test
